// *** verilog/rxaf_regs.svh ***
// constants for the receive address filter control block
// assumes a 16-bit host register port on the same clock as the block
// Behaviour
// R1: bit 7 accepts all broadcast frames
// R2: bit 6 accepts all group frames, broadcast included
// R3: bit 5 accepts unicast matching station address
// R4: bit 4 accepts every frame regardless of address
// R5: bit 1 inverts the address check result
// R6: bit 0 set starts the receive running state
// R7: clearing bit 0 stops after current frame
// R8: software clears run bit before flushing queue
// R9: filter bits sampled at each frame start
`ifndef RXAF_REGS_SVH
`define RXAF_REGS_SVH

// ****************************************************************
// register map
// ****************************************************************
`define RXAF_ADDR_W        12
`define RXAF_CTRL1_OFS     12'h174
`define RXAF_CTRL1_RST     16'h0800

// ****************************************************************
// field positions
// ****************************************************************
`define RXAF_BIT_RUN       0
`define RXAF_BIT_INV       1
`define RXAF_BIT_ALL       4
`define RXAF_BIT_UNI       5
`define RXAF_BIT_GRP       6
`define RXAF_BIT_BCAST     7
`define RXAF_BIT_GROUP_ADR 40
`define RXAF_BCAST_ADR     48'hffff_ffff_ffff

`endif

// *** verilog/rxaf_pkg.sv ***
// types shared by the receive address filter control files
// assumes nothing beyond a SystemVerilog compiler
package rxaf_pkg;

  // receive process states
  typedef enum logic [1:0] {
    RXAF_STOPPED  = 2'b00,  // no frames taken
    RXAF_RUNNING  = 2'b01,  // frames taken in
    RXAF_DRAINING = 2'b10   // run cleared, finishing current frame
  } rxaf_state_t;

endpackage : rxaf_pkg

// *** verilog/rxaf_filt_if.sv ***
// carrier between the control top and its address filter
// assumes both ends sit on the same clock
`timescale 1ns/1ps
interface rxaf_filt_if;
  logic [7:0]  sel;      // filter selection byte
  logic [47:0] dest;     // destination address of the frame
  logic [47:0] station;  // programmed station address
  logic        accept;   // filter verdict

  modport ctrl (output sel, output dest, output station, input accept);
  modport filt (input sel, input dest, input station, output accept);
endinterface : rxaf_filt_if

// *** verilog/rxaf_filter.sv ***
// combinational destination address filter
// assumes the selection byte is stable in the frame start cycle
`timescale 1ns/1ps
`include "rxaf_regs.svh"
module rxaf_filter (
  // carrier from the control top
  rxaf_filt_if.filt f
);

  logic is_bcast;  // all-ones destination
  logic is_group;  // group bit of the first octet
  logic is_match;  // equals station address
  logic normal;    // verdict before inversion

  // ****************************************************************
  // address classification and verdict
  // ****************************************************************
  always_comb begin
    is_bcast = (f.dest == `RXAF_BCAST_ADR);
    is_group = f.dest[`RXAF_BIT_GROUP_ADR];
    is_match = (f.dest == f.station);
    normal   = f.sel[`RXAF_BIT_ALL]                        // R4
             | (is_bcast & f.sel[`RXAF_BIT_BCAST])         // R1
             | (is_group & f.sel[`RXAF_BIT_GRP])           // R2
             | (~is_group & is_match & f.sel[`RXAF_BIT_UNI]); // R3
    // inversion covers the whole verdict, accept-all included
    f.accept = f.sel[`RXAF_BIT_INV] ? ~normal : normal;    // R5
  end

endmodule : rxaf_filter

// *** verilog/rxaf_ctrl.sv ***
// receive control register one and the receive run/stop control
// assumes frame_start/frame_end come from logic on sys_clk
`timescale 1ns/1ps
`include "rxaf_regs.svh"
module rxaf_ctrl (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  // host register port
  input  wire logic [`RXAF_ADDR_W-1:0] host_addr,
  input  wire logic                    host_wr,
  input  wire logic                    host_rd,
  input  wire logic [1:0]              host_be,
  input  wire logic [15:0]             host_wdata,
  output logic      [15:0]             host_rdata_r,
  // frame side
  input  wire logic                    frame_start,
  input  wire logic                    frame_end,
  input  wire logic [47:0]             dest_addr,
  input  wire logic [47:0]             station_addr,
  output logic                         frame_take_r,
  output logic                         frame_drop_r,
  output logic                         rx_running_r,
  output logic [7:0]                   upper_ctrl_r
);

  logic [15:0]          ctrl_r;     // receive_control_one contents
  rxaf_pkg::rxaf_state_t st_r;      // receive process state
  rxaf_pkg::rxaf_state_t st_nxt;    // next state
  logic                 in_frame_r; // an admitted frame is in progress
  logic                 hit;        // register address decoded
  logic                 admit;      // frame start seen while running

  rxaf_filt_if fif ();

  // ****************************************************************
  // filter hookup
  // ****************************************************************
  // the live register byte is used at frame start only; the verdict
  // is latched then, so later writes act from the next frame
  assign fif.sel     = ctrl_r[7:0];  // R9
  assign fif.dest    = dest_addr;
  assign fif.station = station_addr;

  rxaf_filter u_filter (
    .f (fif.filt)
  );

  assign hit   = (host_addr == `RXAF_CTRL1_OFS);
  assign admit = frame_start & (st_r == rxaf_pkg::RXAF_RUNNING);

  // ****************************************************************
  // register write, per byte lane
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_r <= `RXAF_CTRL1_RST;  // R1 R2 R3 R4 R5 R6
    end else if (host_wr && hit) begin
      if (host_be[0]) begin
        ctrl_r[7:0] <= host_wdata[7:0];
      end
      if (host_be[1]) begin
        ctrl_r[15:8] <= host_wdata[15:8];
      end
    end
  end

  // ****************************************************************
  // register read, one cycle latency, unmapped reads zero
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      host_rdata_r <= 16'h0000;
    end else if (host_rd && hit) begin
      host_rdata_r <= ctrl_r;
    end else begin
      host_rdata_r <= 16'h0000;
    end
  end

  // upper byte goes to checksum, flow control and flush logic;
  // flushing with run still set is the software's fault
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      upper_ctrl_r <= 8'(`RXAF_CTRL1_RST >> 8);
    end else begin
      upper_ctrl_r <= ctrl_r[15:8];
    end
  end

  // ****************************************************************
  // frame tracking
  // ****************************************************************
  // end wins over start: a one-cycle frame must not leave the flag set
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      in_frame_r <= 1'b0;
    end else if (frame_end) begin
      in_frame_r <= 1'b0;
    end else if (admit) begin
      in_frame_r <= 1'b1;
    end
  end

  // ****************************************************************
  // run/stop state machine
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      rxaf_pkg::RXAF_STOPPED: begin
        if (ctrl_r[`RXAF_BIT_RUN]) begin
          st_nxt = rxaf_pkg::RXAF_RUNNING;  // R6
        end
      end
      rxaf_pkg::RXAF_RUNNING: begin
        if (!ctrl_r[`RXAF_BIT_RUN]) begin
          // never cut a frame short, one admitted this cycle included
          st_nxt = ((in_frame_r || admit) && !frame_end) ?
                   rxaf_pkg::RXAF_DRAINING :
                   rxaf_pkg::RXAF_STOPPED;  // R7
        end
      end
      rxaf_pkg::RXAF_DRAINING: begin
        if (ctrl_r[`RXAF_BIT_RUN]) begin
          st_nxt = rxaf_pkg::RXAF_RUNNING;
        end else if (frame_end) begin
          st_nxt = rxaf_pkg::RXAF_STOPPED;  // R7
        end
      end
      default: begin
        st_nxt = rxaf_pkg::RXAF_STOPPED;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= rxaf_pkg::RXAF_STOPPED;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_running_r <= 1'b0;
    end else begin
      rx_running_r <= (st_nxt != rxaf_pkg::RXAF_STOPPED);
    end
  end

  // ****************************************************************
  // per-frame verdict pulses
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      frame_take_r <= 1'b0;
      frame_drop_r <= 1'b0;
    end else begin
      frame_take_r <= admit & fif.accept;   // R9
      frame_drop_r <= admit & ~fif.accept;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_bcast_accept: assert property (
    admit && ctrl_r[`RXAF_BIT_BCAST] && !ctrl_r[`RXAF_BIT_INV] &&
    dest_addr == `RXAF_BCAST_ADR |=> frame_take_r)  // R1
    else $error("broadcast frame not taken");

  a_group_accept: assert property (
    admit && ctrl_r[`RXAF_BIT_GRP] && !ctrl_r[`RXAF_BIT_INV] &&
    dest_addr[`RXAF_BIT_GROUP_ADR] |=> frame_take_r)  // R2
    else $error("group frame not taken");

  a_uni_accept: assert property (
    admit && ctrl_r[`RXAF_BIT_UNI] && !ctrl_r[`RXAF_BIT_INV] &&
    !dest_addr[`RXAF_BIT_GROUP_ADR] && dest_addr == station_addr
    |=> frame_take_r)  // R3
    else $error("station unicast not taken");

  a_all_accept: assert property (
    admit && ctrl_r[`RXAF_BIT_ALL] && !ctrl_r[`RXAF_BIT_INV]
    |=> frame_take_r && !frame_drop_r)  // R4
    else $error("accept-all frame not taken");

  a_inverse_reject: assert property (
    admit && ctrl_r[`RXAF_BIT_ALL] && ctrl_r[`RXAF_BIT_INV]
    |=> frame_drop_r && !frame_take_r)  // R5
    else $error("inverse mode took a normally accepted frame");

  a_run_start: assert property (
    st_r == rxaf_pkg::RXAF_STOPPED && ctrl_r[`RXAF_BIT_RUN]
    |=> rx_running_r && st_r != rxaf_pkg::RXAF_STOPPED)  // R6
    else $error("run bit did not start receive");

  a_stop_at_end: assert property (
    st_r == rxaf_pkg::RXAF_RUNNING && !ctrl_r[`RXAF_BIT_RUN] &&
    in_frame_r && !frame_end
    |=> st_r == rxaf_pkg::RXAF_DRAINING && rx_running_r)  // R7
    else $error("receive stopped inside a frame");

  a_one_verdict: assert property (
    in_frame_r && !frame_start |=> !frame_take_r && !frame_drop_r)  // R9
    else $error("verdict given inside a frame");

  c_take_frame: cover property (admit ##1 frame_take_r);
  c_drain_stop: cover property (
    st_r == rxaf_pkg::RXAF_DRAINING ##[1:20]
    st_r == rxaf_pkg::RXAF_STOPPED);
  c_inverse_drop: cover property (
    admit && ctrl_r[`RXAF_BIT_INV] ##1 frame_drop_r);

endmodule : rxaf_ctrl

// *** sim/rxaf_ctrl_tb.sv ***
// self-checking bench for receive control register one and run/stop control
// assumes rxaf_ctrl on one 40 MHz clock with a synchronous active-high reset
`timescale 1ns/1ps
`include "rxaf_regs.svh"
module rxaf_ctrl_tb;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic                    sys_clk;       // 25 ns clock
  logic                    rst;           // synchronous reset
  logic [`RXAF_ADDR_W-1:0] host_addr;     // register address
  logic                    host_wr;       // write strobe
  logic                    host_rd;       // read strobe
  logic [1:0]              host_be;       // byte lanes
  logic [15:0]             host_wdata;    // write data
  logic [15:0]             host_rdata_r;  // read data
  logic                    frame_start;   // first frame cycle
  logic                    frame_end;     // last frame cycle
  logic [47:0]             dest_addr;     // destination address
  logic [47:0]             station_addr;  // station address
  logic                    frame_take_r;  // accept pulse
  logic                    frame_drop_r;  // reject pulse
  logic                    rx_running_r;  // receive process not stopped
  logic [7:0]              upper_ctrl_r;  // upper register byte
  int                      fails;         // mismatch count
  int                      checks;        // comparison count
  logic [15:0]             rd_val;        // last read value
  logic [7:0]              sel_tab [10];  // filter selections
  logic [47:0]             dst_tab [10];  // destinations
  logic                    exp_tab [10];  // expected accept

  // station address keeps the group bit clear
  localparam logic [47:0] STA = 48'h0200_0000_1234;
  localparam logic [47:0] OTH = 48'h0200_0000_9999;
  localparam logic [47:0] GRP = 48'h0100_5e00_0001;
  localparam logic [47:0] BCA = `RXAF_BCAST_ADR;

  rxaf_ctrl u_rxaf_ctrl (.sys_clk(sys_clk), .rst(rst), .host_addr(host_addr),
    .host_wr(host_wr), .host_rd(host_rd), .host_be(host_be),
    .host_wdata(host_wdata), .host_rdata_r(host_rdata_r),
    .frame_start(frame_start), .frame_end(frame_end),
    .dest_addr(dest_addr), .station_addr(station_addr),
    .frame_take_r(frame_take_r), .frame_drop_r(frame_drop_r),
    .rx_running_r(rx_running_r), .upper_ctrl_r(upper_ctrl_r));

  // ****************************************************************
  // clock and shared tasks
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // hangs are cut short well inside the cycle budget
  initial begin
    #100000;
    fails++;
    complete_run();
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask : cyc

  // one-cycle write strobe, all inputs move 2 ns after the edge
  task automatic wr(input logic [11:0] a, input logic [1:0] be,
                    input logic [15:0] d);
    host_addr = a;
    host_be = be;
    host_wdata = d;
    host_wr = 1'b1;
    cyc(1);
    host_wr = 1'b0;
  endtask : wr

  // read data is registered at the strobe edge and stands one cycle;
  // an idle cycle follows so back-to-back reads never retoggle the strobe
  task automatic rd(input logic [11:0] a);
    host_addr = a;
    host_rd = 1'b1;
    cyc(1);
    host_rd = 1'b0;
    rd_val = host_rdata_r;
    cyc(1);
  endtask : rd

  // frame start pulse; td is the expected {take, drop} one cycle later
  task automatic frame(input logic [47:0] d, input logic e,
                       input logic [1:0] td);
    dest_addr = d;
    frame_start = 1'b1;
    frame_end = e;
    cyc(1);
    frame_start = 1'b0;
    frame_end = 1'b0;
    check({14'h0, frame_take_r, frame_drop_r}, {14'h0, td});
  endtask : frame

  task automatic complete_run();
    if (fails == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  // ****************************************************************
  // scenarios
  // ****************************************************************
  // reset value, read-back, byte lanes and an unmapped read
  task automatic reg_access();
    rd(`RXAF_CTRL1_OFS);
    check(rd_val, `RXAF_CTRL1_RST);
    check({15'h0, rx_running_r}, 16'h0000);
    wr(`RXAF_CTRL1_OFS, 2'b01, 16'hfff2);
    rd(`RXAF_CTRL1_OFS);
    check(rd_val, 16'h08f2);
    rd(12'h176);
    check(rd_val, 16'h0000);
    // upper lane alone, flush requested with run already clear
    wr(`RXAF_CTRL1_OFS, 2'b10, 16'ha500);
    cyc(1);
    check({8'h00, upper_ctrl_r}, 16'h00a5);
    rd(`RXAF_CTRL1_OFS);
    check(rd_val, 16'ha5f2);
    wr(`RXAF_CTRL1_OFS, 2'b11, 16'h0800);
  endtask : reg_access

  // broadcast, unicast and inverted unicast each against a matching and a missing destination; group and accept-all against matches only
  task automatic filter_table();
    frame(BCA, 1'b1, 2'b00);
    wr(`RXAF_CTRL1_OFS, 2'b11, 16'h0801);
    cyc(1);
    check({15'h0, rx_running_r}, 16'h0001);
    for (int i = 0; i < 10; i++) begin
      wr(`RXAF_CTRL1_OFS, 2'b11, {8'h08, sel_tab[i]});
      frame(dst_tab[i], 1'b1, {exp_tab[i], !exp_tab[i]});
    end
  endtask : filter_table

  // run cleared mid-frame: drains until frame end, refuses new starts
  task automatic stop_mid_frame();
    wr(`RXAF_CTRL1_OFS, 2'b11, 16'h0811);
    frame(OTH, 1'b0, 2'b10);
    wr(`RXAF_CTRL1_OFS, 2'b11, 16'h0810);
    cyc(2);
    check({15'h0, rx_running_r}, 16'h0001);
    frame(OTH, 1'b0, 2'b00);
    cyc(1);
    frame_end = 1'b1;
    cyc(1);
    frame_end = 1'b0;
    cyc(2);
    check({15'h0, rx_running_r}, 16'h0000);
    frame(OTH, 1'b1, 2'b00);
  endtask : stop_mid_frame

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    fails = 0;
    checks = 0;
    rst = 1'b1;
    host_addr = '0;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_be = 2'b00;
    host_wdata = '0;
    frame_start = 1'b0;
    frame_end = 1'b0;
    dest_addr = '0;
    station_addr = STA;
    sel_tab = '{8'h81, 8'h81, 8'h41, 8'h41, 8'h21, 8'h21, 8'h11, 8'h23,
                8'h23, 8'h13};
    dst_tab = '{BCA, GRP, GRP, BCA, STA, OTH, OTH, STA, OTH, BCA};
    exp_tab = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1,
                1'b0};
    cyc(5);
    rst = 1'b0;
    check({8'h00, upper_ctrl_r}, 16'h0008);
    reg_access();
    filter_table();
    stop_mid_frame();
    complete_run();
  end
endmodule : rxaf_ctrl_tb
